/* File: hw/ciowm_pkg.sv */
package ciowm_pkg;
	// register indices, reached directly or at the mapped page plus index
	localparam logic [7:0] IDX_WIN_ENABLE = 8'h06;
	localparam logic [7:0] IDX_IO_CTRL = 8'h07;
	localparam logic [7:0] IDX_IO0_START_LO = 8'h08;
	localparam logic [7:0] IDX_IO0_START_HI = 8'h09;
	localparam logic [7:0] IDX_IO0_STOP_LO = 8'h0a;
	localparam logic [7:0] IDX_IO0_STOP_HI = 8'h0b;
	localparam logic [7:0] IDX_IO1_START_LO = 8'h0c;
	localparam logic [7:0] IDX_IO1_START_HI = 8'h0d;
	localparam logic [7:0] IDX_IO1_STOP_LO = 8'h0e;
	localparam logic [7:0] IDX_IO1_STOP_HI = 8'h0f;
	localparam logic [7:0] IDX_IO0_OFF_LO = 8'h36;
	localparam logic [7:0] IDX_IO0_OFF_HI = 8'h37;
	localparam logic [7:0] IDX_IO1_OFF_LO = 8'h38;
	localparam logic [7:0] IDX_IO1_OFF_HI = 8'h39;
	localparam logic [3:0] MM_PAGE = 4'h8;
	// enable register fields
	localparam int EN_IO0_BIT = 6;
	localparam int EN_FINE_BIT = 5;
	localparam int MEM_WIN_CNT = 5;
	// io control fields, one nibble per window
	localparam int CTRL_SIZE_BIT = 0;
	localparam int CTRL_SRC_BIT = 1;
	localparam int CTRL_ZW_BIT = 2;
	localparam int CTRL_WS_BIT = 3;
	localparam int CTRL_STRIDE = 4;
	localparam logic [7:0] REG_RST = 8'h00;
	localparam logic [15:0] WORD_RST = 16'h0000;
	// card i/o cycle lengths in isa cycles
	localparam logic [2:0] CYC16_STD = 3'h3;
	localparam logic [2:0] CYC16_EXT = 3'h4;
	localparam logic [2:0] CYC8_STD = 3'h6;
	localparam logic [2:0] CYC8_ZW = 3'h3;
	// coarse decode keeps a23..a17 only
	localparam logic [11:0] COARSE_MASK = 12'hfe0;
	typedef enum logic [1:0] {
		ACC_NONE = 2'b00,
		ACC_INDEX = 2'b01,
		ACC_MMAP = 2'b10
	} ciowm_acc_t;
endpackage

/* File: hw/ciowm_win_if.sv */
`timescale 1ns/1ps
interface ciowm_win_if;
	logic en;
	logic [15:0] start;
	logic [15:0] stop;
	logic [15:0] offset;
	logic [3:0] ctrl;
	logic [15:0] host_addr;
	logic card_wide;
	logic hit;
	logic wide;
	logic [15:0] card_addr;
	logic [2:0] cycles;
	modport cfg (
		output en, start, stop, offset, ctrl, host_addr, card_wide,
		input hit, wide, card_addr, cycles
	);
	modport dec (
		input en, start, stop, offset, ctrl, host_addr, card_wide,
		output hit, wide, card_addr, cycles
	);
endinterface

/* File: hw/ciowm_win_dec.sv */
`timescale 1ns/1ps
module ciowm_win_dec
	import ciowm_pkg::*;
(
	ciowm_win_if.dec win
);
	always_comb begin
		// inclusive range gives a one byte window when start equals stop
		win.hit = win.en && (win.host_addr >= win.start) &&
			(win.host_addr <= win.stop);
		win.card_addr = win.host_addr + win.offset;
		if (win.ctrl[CTRL_SRC_BIT]) begin
			win.wide = win.card_wide;
		end else begin
			win.wide = win.ctrl[CTRL_SIZE_BIT];
		end
		if (win.wide) begin
			win.cycles = win.ctrl[CTRL_WS_BIT] ? CYC16_EXT : CYC16_STD;
		end else begin
			win.cycles = win.ctrl[CTRL_ZW_BIT] ? CYC8_ZW : CYC8_STD;
		end
	end
endmodule

/* File: hw/ciowm_top.sv */
`timescale 1ns/1ps
// Contract
// - bits 7/6 gate i/o windows 1/0
// - bits 4..0 enable memory windows 4..0
// - bit 5 picks 4K or 128K decode
// - wait bit: 16-bit cycles 3 or 4
// - zero-wait bit: 8-bit cycles 6 or 3
// - source clear: wide select from size bit
// - source set: wide select from card
// - size bit: 8-bit at zero, 16-bit at one
// - window 0 start from two bytes
// - window 0 stop from two bytes
// - window 1 start/stop from byte pairs
// - window 0 offset low at 36h
// - registers reachable by index and 800h page
// - window 0 offset high at 37h
// - window 1 offset at 38h/39h
module ciowm_top
	import ciowm_pkg::*;
(
	input wire logic sys_clk_in,
	input wire logic arst_n_in,
	input wire logic idx_wr_in,
	input wire logic dat_wr_in,
	input wire logic dat_rd_in,
	input wire logic mm_wr_in,
	input wire logic mm_rd_in,
	input wire logic [11:0] mm_addr_in,
	input wire logic [7:0] wdata_in,
	output logic [7:0] rdata_out,
	input wire logic host_io_valid_in,
	input wire logic [15:0] host_io_addr_in,
	input wire logic [23:12] host_mem_addr_in,
	input wire logic card_io_wide_indicate_n_in,
	output logic io_hit_out,
	output logic io_win_out,
	output logic [15:0] card_addr_out,
	output logic host_io_wide_select_n_out,
	output logic io_wide_path_out,
	output logic [2:0] io_cycle_isa_out,
	output logic [MEM_WIN_CNT-1:0] mem_win_en_out,
	output logic fine_memory_decode_out,
	output logic [11:0] mem_decode_addr_out
);
	logic [7:0] idx_reg;
	logic [7:0] win_en_reg;
	logic [7:0] io_ctrl_reg;
	logic [15:0] io_start_reg [2];
	logic [15:0] io_stop_reg [2];
	logic [15:0] io_off_reg [2];
	logic sync1_reg;
	logic sync2_reg;
	logic sync3_reg;
	logic card_wide_reg;
	ciowm_acc_t wr_src;
	ciowm_acc_t rd_src;
	logic [7:0] wr_idx;
	logic [7:0] rd_idx;
	logic [7:0] rd_val;
	logic mm_wr_hit;
	logic mm_rd_hit;

	// the mapped page only answers at 8xxh
	assign mm_wr_hit = mm_wr_in && (mm_addr_in[11:8] == MM_PAGE);
	assign mm_rd_hit = mm_rd_in && (mm_addr_in[11:8] == MM_PAGE);

	// mapped access wins if both paths strike in one cycle
	always_comb begin
		wr_src = ACC_NONE;
		wr_idx = idx_reg;
		if (mm_wr_hit) begin
			wr_src = ACC_MMAP;
			wr_idx = mm_addr_in[7:0];
		end else if (dat_wr_in) begin
			wr_src = ACC_INDEX;
		end
	end

	always_comb begin
		rd_src = ACC_NONE;
		rd_idx = idx_reg;
		if (mm_rd_hit) begin
			rd_src = ACC_MMAP;
			rd_idx = mm_addr_in[7:0];
		end else if (dat_rd_in) begin
			rd_src = ACC_INDEX;
		end
	end

	always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			idx_reg <= REG_RST;
		end else if (idx_wr_in) begin
			idx_reg <= wdata_in;
		end
	end

	always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			win_en_reg <= REG_RST;
			io_ctrl_reg <= REG_RST;
		end else if (wr_src != ACC_NONE) begin
			case (wr_idx)
				IDX_WIN_ENABLE: begin
					win_en_reg <= wdata_in;
				end
				IDX_IO_CTRL: begin
					io_ctrl_reg <= wdata_in;
				end
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			for (int i = 0; i < 2; i++) begin
				io_start_reg[i] <= WORD_RST;
				io_stop_reg[i] <= WORD_RST;
				io_off_reg[i] <= WORD_RST;
			end
		end else if (wr_src != ACC_NONE) begin
			case (wr_idx)
				IDX_IO0_START_LO: begin
					io_start_reg[0][7:0] <= wdata_in;
				end
				IDX_IO0_START_HI: begin
					io_start_reg[0][15:8] <= wdata_in;
				end
				IDX_IO0_STOP_LO: begin
					io_stop_reg[0][7:0] <= wdata_in;
				end
				IDX_IO0_STOP_HI: begin
					io_stop_reg[0][15:8] <= wdata_in;
				end
				IDX_IO1_START_LO: begin
					io_start_reg[1][7:0] <= wdata_in;
				end
				IDX_IO1_START_HI: begin
					io_start_reg[1][15:8] <= wdata_in;
				end
				IDX_IO1_STOP_LO: begin
					io_stop_reg[1][7:0] <= wdata_in;
				end
				IDX_IO1_STOP_HI: begin
					io_stop_reg[1][15:8] <= wdata_in;
				end
				IDX_IO0_OFF_LO: begin
					io_off_reg[0][7:0] <= wdata_in;
				end
				IDX_IO0_OFF_HI: begin
					io_off_reg[0][15:8] <= wdata_in;
				end
				IDX_IO1_OFF_LO: begin
					io_off_reg[1][7:0] <= wdata_in;
				end
				IDX_IO1_OFF_HI: begin
					io_off_reg[1][15:8] <= wdata_in;
				end
				default: begin
				end
			endcase
		end
	end

	// unmapped indices read as zero
	always_comb begin
		case (rd_idx)
			IDX_WIN_ENABLE: rd_val = win_en_reg;
			IDX_IO_CTRL: rd_val = io_ctrl_reg;
			IDX_IO0_START_LO: rd_val = io_start_reg[0][7:0];
			IDX_IO0_START_HI: rd_val = io_start_reg[0][15:8];
			IDX_IO0_STOP_LO: rd_val = io_stop_reg[0][7:0];
			IDX_IO0_STOP_HI: rd_val = io_stop_reg[0][15:8];
			IDX_IO1_START_LO: rd_val = io_start_reg[1][7:0];
			IDX_IO1_START_HI: rd_val = io_start_reg[1][15:8];
			IDX_IO1_STOP_LO: rd_val = io_stop_reg[1][7:0];
			IDX_IO1_STOP_HI: rd_val = io_stop_reg[1][15:8];
			IDX_IO0_OFF_LO: rd_val = io_off_reg[0][7:0];
			IDX_IO0_OFF_HI: rd_val = io_off_reg[0][15:8];
			IDX_IO1_OFF_LO: rd_val = io_off_reg[1][7:0];
			IDX_IO1_OFF_HI: rd_val = io_off_reg[1][15:8];
			default: rd_val = REG_RST;
		endcase
	end

	always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			rdata_out <= REG_RST;
		end else if (rd_src != ACC_NONE) begin
			rdata_out <= rd_val;
		end
	end

	// card pin is asynchronous; accept a level once stages 2 and 3 agree
	always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			sync1_reg <= 1'b1;
			sync2_reg <= 1'b1;
			sync3_reg <= 1'b1;
			card_wide_reg <= 1'b0;
		end else begin
			sync1_reg <= card_io_wide_indicate_n_in;
			sync2_reg <= sync1_reg;
			sync3_reg <= sync2_reg;
			if (sync2_reg == sync3_reg) begin
				card_wide_reg <= !sync3_reg;
			end
		end
	end

	ciowm_win_if win_if [2] ();

	for (genvar w = 0; w < 2; w++) begin : g_win
		// software must set start/stop first; no hold-off is applied here
		assign win_if[w].en = win_en_reg[EN_IO0_BIT + w];
		assign win_if[w].start = io_start_reg[w];
		assign win_if[w].stop = io_stop_reg[w];
		assign win_if[w].offset = io_off_reg[w];
		assign win_if[w].ctrl = io_ctrl_reg[CTRL_STRIDE*w +: CTRL_STRIDE];
		assign win_if[w].host_addr = host_io_addr_in;
		assign win_if[w].card_wide = card_wide_reg;
		ciowm_win_dec u_dec (
			.win(win_if[w])
		);
	end

	// window 0 takes an address that both windows claim
	always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			io_hit_out <= 1'b0;
			io_win_out <= 1'b0;
			card_addr_out <= WORD_RST;
			host_io_wide_select_n_out <= 1'b1;
			io_wide_path_out <= 1'b0;
			io_cycle_isa_out <= CYC8_STD;
		end else if (host_io_valid_in && win_if[0].hit) begin
			io_hit_out <= 1'b1;
			io_win_out <= 1'b0;
			card_addr_out <= win_if[0].card_addr;
			host_io_wide_select_n_out <= !win_if[0].wide;
			io_wide_path_out <= win_if[0].wide;
			io_cycle_isa_out <= win_if[0].cycles;
		end else if (host_io_valid_in && win_if[1].hit) begin
			io_hit_out <= 1'b1;
			io_win_out <= 1'b1;
			card_addr_out <= win_if[1].card_addr;
			host_io_wide_select_n_out <= !win_if[1].wide;
			io_wide_path_out <= win_if[1].wide;
			io_cycle_isa_out <= win_if[1].cycles;
		end else begin
			io_hit_out <= 1'b0;
			host_io_wide_select_n_out <= 1'b1;
		end
	end

	always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			mem_win_en_out <= '0;
			fine_memory_decode_out <= 1'b0;
			mem_decode_addr_out <= 12'h000;
		end else begin
			mem_win_en_out <= win_en_reg[MEM_WIN_CNT-1:0];
			fine_memory_decode_out <= win_en_reg[EN_FINE_BIT];
			if (win_en_reg[EN_FINE_BIT]) begin
				mem_decode_addr_out <= host_mem_addr_in;
			end else begin
				mem_decode_addr_out <= host_mem_addr_in & COARSE_MASK;
			end
		end
	end

	// checks
	sequence s_en_write;
		(wr_src != ACC_NONE) && (wr_idx == IDX_WIN_ENABLE);
	endsequence

	sequence s_claim0;
		host_io_valid_in && win_if[0].hit;
	endsequence

	property p_index_write;
		@(posedge sys_clk_in) disable iff (!arst_n_in)
		dat_wr_in && !mm_wr_hit && (idx_reg == IDX_IO0_OFF_LO)
			|=> io_off_reg[0][7:0] == $past(wdata_in);
	endproperty
	a_index_write: assert property (p_index_write)
		else $error("index write to offset low not stored");

	property p_mmap_read;
		@(posedge sys_clk_in) disable iff (!arst_n_in)
		mm_rd_in && (mm_addr_in == 12'h806) |=> rdata_out == $past(win_en_reg);
	endproperty
	a_mmap_read: assert property (p_mmap_read)
		else $error("mapped read of enable register wrong");

	property p_mem_enable;
		@(posedge sys_clk_in) disable iff (!arst_n_in)
		s_en_write ##2 1'b1
			|-> mem_win_en_out == $past(wdata_in[MEM_WIN_CNT-1:0], 2);
	endproperty
	a_mem_enable: assert property (p_mem_enable)
		else $error("memory window enables do not follow register");

	property p_io_gate;
		@(posedge sys_clk_in) disable iff (!arst_n_in)
		io_hit_out |-> (io_win_out ? $past(win_en_reg[EN_IO0_BIT + 1])
			: $past(win_en_reg[EN_IO0_BIT]));
	endproperty
	a_io_gate: assert property (p_io_gate)
		else $error("disabled i/o window claimed an access");

	property p_coarse;
		@(posedge sys_clk_in) disable iff (!arst_n_in)
		!fine_memory_decode_out |-> mem_decode_addr_out[4:0] == 5'h00;
	endproperty
	a_coarse: assert property (p_coarse)
		else $error("coarse decode passed low address bits");

	property p_cycles16;
		@(posedge sys_clk_in) disable iff (!arst_n_in)
		(s_claim0 and win_if[0].wide) |=>
			io_cycle_isa_out == ($past(io_ctrl_reg[CTRL_WS_BIT]) ? 3'h4 : 3'h3);
	endproperty
	a_cycles16: assert property (p_cycles16)
		else $error("16-bit cycle length wrong");

	property p_cycles8;
		@(posedge sys_clk_in) disable iff (!arst_n_in)
		(s_claim0 and !win_if[0].wide) |=>
			io_cycle_isa_out == ($past(io_ctrl_reg[CTRL_ZW_BIT]) ? 3'h3 : 3'h6);
	endproperty
	a_cycles8: assert property (p_cycles8)
		else $error("8-bit cycle length wrong");

	property p_sel_size;
		@(posedge sys_clk_in) disable iff (!arst_n_in)
		(s_claim0 and !io_ctrl_reg[CTRL_SRC_BIT])
			|=> host_io_wide_select_n_out == !$past(io_ctrl_reg[CTRL_SIZE_BIT]);
	endproperty
	a_sel_size: assert property (p_sel_size)
		else $error("wide select not taken from size bit");

	property p_sel_card;
		@(posedge sys_clk_in) disable iff (!arst_n_in)
		(s_claim0 and io_ctrl_reg[CTRL_SRC_BIT])
			|=> host_io_wide_select_n_out == !$past(card_wide_reg);
	endproperty
	a_sel_card: assert property (p_sel_card)
		else $error("wide select not taken from card");

	property p_translate;
		@(posedge sys_clk_in) disable iff (!arst_n_in)
		io_hit_out |-> card_addr_out == 16'($past(host_io_addr_in) +
			(io_win_out ? $past(io_off_reg[1]) : $past(io_off_reg[0])));
	endproperty
	a_translate: assert property (p_translate)
		else $error("card address not host address plus offset");

	property p_range;
		@(posedge sys_clk_in) disable iff (!arst_n_in)
		host_io_valid_in && win_en_reg[EN_IO0_BIT] &&
			(host_io_addr_in == io_start_reg[0]) &&
			(io_start_reg[0] <= io_stop_reg[0])
			|=> io_hit_out && !io_win_out;
	endproperty
	a_range: assert property (p_range)
		else $error("start address of window 0 not claimed");

	property p_idle_release;
		@(posedge sys_clk_in) disable iff (!arst_n_in)
		!host_io_valid_in |=> !io_hit_out && host_io_wide_select_n_out;
	endproperty
	a_idle_release: assert property (p_idle_release)
		else $error("outputs active without an access");
endmodule

/* File: tb/ciowm_card_model.sv */
`timescale 1ns/1ps
module ciowm_card_model (
	input wire logic wide_req_in,
	output logic card_io_wide_indicate_n_out
);
	initial card_io_wide_indicate_n_out = 1'b1;
	// pin moves off the host clock grid, as a real card's would
	always @(wide_req_in) begin
		card_io_wide_indicate_n_out <= #1.3 ~wide_req_in;
	end
endmodule

/* File: tb/testbench.sv */
`timescale 1ns/1ps
module testbench;
	import ciowm_pkg::*;
	typedef struct packed {
		logic hit;
		logic win;
		logic [15:0] addr;
		logic sel_n;
		logic path;
		logic chk_path;
		logic [2:0] cyc;
	} ciowm_exp_t;
	logic sys_clk_in = 1'b0;
	logic arst_n_in = 1'b0;
	logic idx_wr_in = 1'b0, dat_wr_in = 1'b0, dat_rd_in = 1'b0;
	logic mm_wr_in = 1'b0, mm_rd_in = 1'b0, host_io_valid_in = 1'b0;
	logic [11:0] mm_addr_in = 12'h000;
	logic [7:0] wdata_in = 8'h00;
	logic [15:0] host_io_addr_in = 16'h0000;
	logic [23:12] host_mem_addr_in = 12'h000;
	logic card_n, cw = 1'b0, rs, vs;
	logic [7:0] rdata_out;
	logic io_hit_out, io_win_out, sel_n_out, wide_out, fine_out;
	logic [15:0] card_addr_out;
	logic [2:0] cyc_out;
	logic [MEM_WIN_CNT-1:0] mem_en_out;
	logic [11:0] mem_addr_out;
	logic [7:0] sh [256];
	logic [7:0] v;
	logic [15:0] a;
	int errors = 0;
	int num_checks = 0;
	logic [7:0] rd_q [$];
	ciowm_exp_t io_q [$];
	logic [7:0] idx_tab [14] = '{IDX_WIN_ENABLE, IDX_IO_CTRL,
		IDX_IO0_START_LO, IDX_IO0_START_HI, IDX_IO0_STOP_LO,
		IDX_IO0_STOP_HI, IDX_IO1_START_LO, IDX_IO1_START_HI,
		IDX_IO1_STOP_LO, IDX_IO1_STOP_HI, IDX_IO0_OFF_LO,
		IDX_IO0_OFF_HI, IDX_IO1_OFF_LO, IDX_IO1_OFF_HI};
	// index in high byte, value in low byte
	logic [15:0] cfg_tab [12] = '{16'h08f0, 16'h0901, 16'h0af7,
		16'h0b01, 16'h0cf4, 16'h0d01, 16'h0eff, 16'h0f02, 16'h3610,
		16'h3700, 16'h3800, 16'h39ff};
	logic [15:0] adr_tab [8] = '{16'h01ef, 16'h01f0, 16'h01f7,
		16'h01f8, 16'h02ff, 16'h0300, 16'h01f5, 16'h0000};

	ciowm_top u_ciowm_top (.sys_clk_in(sys_clk_in), .arst_n_in(arst_n_in),
		.idx_wr_in(idx_wr_in), .dat_wr_in(dat_wr_in),
		.dat_rd_in(dat_rd_in), .mm_wr_in(mm_wr_in), .mm_rd_in(mm_rd_in),
		.mm_addr_in(mm_addr_in), .wdata_in(wdata_in),
		.rdata_out(rdata_out), .host_io_valid_in(host_io_valid_in),
		.host_io_addr_in(host_io_addr_in),
		.host_mem_addr_in(host_mem_addr_in),
		.card_io_wide_indicate_n_in(card_n), .io_hit_out(io_hit_out),
		.io_win_out(io_win_out), .card_addr_out(card_addr_out),
		.host_io_wide_select_n_out(sel_n_out),
		.io_wide_path_out(wide_out), .io_cycle_isa_out(cyc_out),
		.mem_win_en_out(mem_en_out), .fine_memory_decode_out(fine_out),
		.mem_decode_addr_out(mem_addr_out));
	ciowm_card_model u_ciowm_card_model (.wide_req_in(cw),
		.card_io_wide_indicate_n_out(card_n));

	always #2 sys_clk_in = ~sys_clk_in;

	task stop_test;
		if (errors == 0 && num_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	task chk(input string n, input logic [15:0] e, input logic [15:0] g);
		num_checks++;
		if (g !== e) begin
			errors++;
			$display("CHECK FAILED %s exp %h got %h", n, e, g);
		end
	endtask

	task cmp_rd(input logic [7:0] e);
		chk("rdata", {8'h00, e}, {8'h00, rdata_out});
	endtask

	task cmp_io(input ciowm_exp_t e);
		chk("hit", e.hit, io_hit_out);
		chk("select_n", e.sel_n, sel_n_out);
		if (e.hit) begin
			chk("win", e.win, io_win_out);
			chk("card_addr", e.addr, card_addr_out);
			chk("cycles", e.cyc, cyc_out);
			if (e.chk_path)
				chk("path", e.path, wide_out);
		end
	endtask

	task cyc;
		@(posedge sys_clk_in);
		#1;
	endtask

	// results register on the request edge and are checked 2 ns later, at the next falling edge
	always @(posedge sys_clk_in) begin
		rs = dat_rd_in | (mm_rd_in & (mm_addr_in[11:8] == MM_PAGE));
		vs = host_io_valid_in;
		#2;
		if (rs && rd_q.size() > 0)
			cmp_rd(rd_q.pop_front());
		if (vs && io_q.size() > 0)
			cmp_io(io_q.pop_front());
	end

	task wr(input logic [7:0] idx, input logic [7:0] d, input logic mm);
		cyc;
		if (mm) begin
			mm_wr_in = 1'b1;
			mm_addr_in = {MM_PAGE, idx};
		end else begin
			idx_wr_in = 1'b1;
			wdata_in = idx;
			cyc;
			idx_wr_in = 1'b0;
			dat_wr_in = 1'b1;
		end
		wdata_in = d;
		cyc;
		mm_wr_in = 1'b0;
		dat_wr_in = 1'b0;
		sh[idx] = d;
	endtask

	task rd(input logic [7:0] idx, input logic mm);
		cyc;
		if (mm) begin
			mm_rd_in = 1'b1;
			mm_addr_in = {MM_PAGE, idx};
		end else begin
			idx_wr_in = 1'b1;
			wdata_in = idx;
			cyc;
			idx_wr_in = 1'b0;
			dat_rd_in = 1'b1;
		end
		rd_q.push_back(sh[idx]);
		cyc;
		mm_rd_in = 1'b0;
		dat_rd_in = 1'b0;
	endtask

	task regs(input logic mm);
		for (int i = 0; i < 14; i++)
			rd(idx_tab[i], mm);
	endtask

	task io(input logic [15:0] ad);
		ciowm_exp_t e;
		logic h0, h1, w, wd;
		logic [3:0] c;
		h0 = sh[6][6] && ad >= {sh[9], sh[8]} && ad <= {sh[11], sh[10]};
		h1 = sh[6][7] && ad >= {sh[13], sh[12]} && ad <= {sh[15], sh[14]};
		w = !h0;
		c = w ? sh[7][7:4] : sh[7][3:0];
		wd = c[CTRL_SRC_BIT] ? cw : c[CTRL_SIZE_BIT];
		e.hit = h0 | h1;
		e.win = w;
		e.addr = ad + (w ? {sh[57], sh[56]} : {sh[55], sh[54]});
		e.sel_n = !(e.hit && wd);
		e.path = c[CTRL_SIZE_BIT];
		e.chk_path = !c[CTRL_SRC_BIT];
		e.cyc = wd ? (c[CTRL_WS_BIT] ? 3'h4 : 3'h3)
			: (c[CTRL_ZW_BIT] ? 3'h3 : 3'h6);
		cyc;
		host_io_valid_in = 1'b1;
		host_io_addr_in = ad;
		io_q.push_back(e);
		cyc;
		host_io_valid_in = 1'b0;
	endtask

	task do_reset;
		arst_n_in = 1'b0;
		cw = 1'b0;
		foreach (sh[i])
			sh[i] = 8'h00;
		repeat (20) cyc;
		arst_n_in = 1'b1;
	endtask

	initial begin
		repeat (100000) @(posedge sys_clk_in);
		errors++;
		stop_test;
	end

	initial begin
		void'($urandom(32'h493c_0974));
		do_reset;
		chk("select_n", 16'h0001, sel_n_out);
		chk("cycles", 16'h0006, cyc_out);
		regs(1'b0);
		regs(1'b1);
		io(16'h01f2);
		for (int i = 0; i < 14; i++)
			wr(idx_tab[i], 8'($urandom), i[0]);
		regs(1'b0);
		regs(1'b1);
		// mapped access off the 8xxh page must be ignored
		cyc;
		mm_wr_in = 1'b1;
		mm_addr_in = 12'h706;
		wdata_in = 8'hff;
		cyc;
		mm_wr_in = 1'b0;
		rd(IDX_WIN_ENABLE, 1'b1);
		rd(8'h20, 1'b0);
		for (int i = 0; i < 2; i++) begin
			v = 8'($urandom);
			v[EN_FINE_BIT] = i[0];
			host_mem_addr_in = 12'($urandom);
			wr(IDX_WIN_ENABLE, v, i[0]);
			repeat (2) cyc;
			chk("mem_en", v[4:0], mem_en_out);
			chk("fine", v[5], fine_out);
			chk("mem_addr", v[5] ? host_mem_addr_in
				: {host_mem_addr_in[23:17], 5'h00}, mem_addr_out);
		end
		wr(IDX_WIN_ENABLE, 8'h00, 1'b0);
		wr(IDX_IO_CTRL, 8'h00, 1'b0);
		for (int i = 0; i < 12; i++)
			wr(cfg_tab[i][15:8], cfg_tab[i][7:0], i[0]);
		wr(IDX_WIN_ENABLE, 8'hc0, 1'b0);
		foreach (adr_tab[i])
			io(adr_tab[i]);
		for (int c = 0; c < 16; c++) begin
			cw = 1'($urandom);
			wr(IDX_IO_CTRL, {c[3:0], 4'(c + 5)}, c[0]);
			repeat (6) cyc;
			io(16'h01f2);
			io(16'h0250);
		end
		wr(IDX_WIN_ENABLE, 8'h80, 1'b1);
		io(16'h01f5);
		io(16'h01f2);
		wr(IDX_WIN_ENABLE, 8'h40, 1'b1);
		io(16'h0250);
		wr(IDX_WIN_ENABLE, 8'hc0, 1'b0);
		for (int i = 0; i < 30; i++) begin
			a = 16'h01e0 + 16'($urandom_range(304, 0));
			io(a);
		end
		wr(IDX_IO1_START_LO, 8'h00, 1'b0);
		wr(IDX_IO1_START_HI, 8'h03, 1'b0);
		wr(IDX_IO1_STOP_LO, 8'h00, 1'b0);
		wr(IDX_IO1_STOP_HI, 8'h03, 1'b0);
		io(16'h02ff);
		io(16'h0300);
		io(16'h0301);
		repeat (2) cyc;
		do_reset;
		regs(1'b1);
		io(16'h0300);
		repeat (3) cyc;
		stop_test;
	end
endmodule
